// file: bench/host_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------
// Host memory model
// ------------------
module host_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Words from the device
  input  wire logic        host_valid,
  output logic             host_ready,
  input  wire logic [7:0]  host_data,
  input  wire logic [16:0] host_addr,
  input  wire logic        host_burst_end,
  // Pacing and record
  input  wire logic        slow,
  output logic      [16:0] last_addr,
  output logic      [7:0]  last_data,
  output logic      [7:0]  burst_cnt
);
  logic [1:0] tick_reg;

  // One word in three when slow, so the device buffer fills
  assign host_ready = !slow || (tick_reg == 2'h0);

  // Flat space: room past the ring end always exists
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg  <= 2'h0;
      last_addr <= 17'h0;
      last_data <= 8'h0;
      burst_cnt <= 8'h0;
    end else begin
      tick_reg <= (tick_reg == 2'h2) ? 2'h0 : tick_reg + 2'h1;
      if (host_valid && host_ready) begin
        last_addr <= host_addr;
        last_data <= host_data;
        burst_cnt <= burst_cnt + {7'h0, host_burst_end};
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/rx_cfg_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "rx_cfg_defines.svh"
// ------------------
// Port checker
// ------------------
module rx_cfg_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [3:0]  reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Receive stream
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        rx_last,
  input wire logic [10:0] rx_fifo_bytes,
  input wire logic        rx_fifo_pkt_complete,
  // Host writes and verdict
  input wire logic        host_valid,
  input wire logic        host_ready,
  input wire logic [7:0]  host_data,
  input wire logic [16:0] host_addr,
  input wire logic        host_last,
  input wire logic        host_burst_end,
  input wire logic        rx_dma_active,
  input wire logic        rx_done,
  input wire logic        rx_accepted,
  input wire logic        received_error_flag,
  input wire logic        early_irq,
  input wire logic [16:0] ring_size,
  input wire logic [10:0] rx_burst_limit
);
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [2:0]  thr_code;

  // Shadow of the configuration word
  always_comb begin
    cfg_next = cfg_reg;
    for (int k = 0; k < 4; k++) begin
      if (reg_be[k]) begin
        cfg_next[k*8 +: 8] = reg_wdata[k*8 +: 8];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `RCFG_RESET;
    end else if (reg_wr_en && reg_addr == `RCFG_OFFSET) begin
      cfg_reg <= cfg_next & `RCFG_WMASK;
    end
  end
  assign thr_code = cfg_reg[15:13];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Last byte taken; two cycles free of writes
  sequence s_last_take;
    rx_valid && rx_ready && rx_last;
  endsequence
  sequence s_quiet_regs;
    !reg_wr_en [*2];
  endsequence

  a_hold_stalled_word: assert property (
    host_valid && !host_ready |=> host_valid &&
      $stable({host_data, host_addr, host_last, host_burst_end}))
    else $error("host word changed while stalled");
  a_last_ends_burst: assert property (host_last |-> host_burst_end)
    else $error("open burst at last");
  a_ready_drops_last: assert property (s_last_take |=> !rx_ready)
    else $error("rx_ready stayed high after last byte");
  a_verdict_follows: assert property (
    s_last_take |=> rx_done && !rx_dma_active ##1 !rx_done)
    else $error("verdict pulse missing or stretched");
  a_flag_needs_accept: assert property (
    rx_done && received_error_flag |-> rx_accepted)
    else $error("error flag on a dropped frame");
  a_start_threshold: assert property (
    $rose(rx_ready) |-> $past(rx_fifo_pkt_complete) ||
      ($past(thr_code) != `WHOLE_PKT &&
       $past(rx_fifo_bytes) >= (`THR_BASE << $past(thr_code))))
    else $error("transfer started below threshold");
  a_ring_size_code: assert property (
    s_quiet_regs |-> ring_size == (`RING_BASE << cfg_reg[12:11]))
    else $error("ring size does not follow its code");
  a_burst_limit_code: assert property (
    s_quiet_regs |-> rx_burst_limit == ((cfg_reg[10:8] == `NO_LIMIT) ?
      11'h000 : (`THR_BASE << cfg_reg[10:8])))
    else $error("burst limit does not follow its code");
  a_config_readback: assert property (
    reg_rd_en && !reg_wr_en && reg_addr == `RCFG_OFFSET
      |=> reg_rdata == cfg_reg)
    else $error("configuration read differs from writes");
  a_unmapped_zero: assert property (
    reg_rd_en && !(reg_addr inside {`RCFG_OFFSET, `MULTI_IRQ_OFFSET,
      `RING_PTR_OFFSET}) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_early_one_pulse: assert property (early_irq |=> !early_irq)
    else $error("early event longer than a cycle");
endmodule

bind rx_config_filter_dma rx_cfg_chk i_rx_cfg_chk (
  .clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_be, .reg_wdata,
  .reg_rdata, .rx_valid, .rx_ready, .rx_last, .rx_fifo_bytes,
  .rx_fifo_pkt_complete, .host_valid, .host_ready, .host_data, .host_addr,
  .host_last, .host_burst_end, .rx_dma_active, .rx_done, .rx_accepted,
  .received_error_flag, .early_irq, .ring_size, .rx_burst_limit);
`default_nettype wire

// file: bench/rx_config_filter_dma_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "rx_cfg_defines.svh"
module rx_config_filter_dma_test;
  logic        clk, rst_n, reg_wr_en, reg_rd_en, rx_valid, rx_last, slow;
  logic        rx_ready, rx_fifo_pkt_complete, rx_known_protocol, rx_done;
  logic        st_broadcast, st_multicast, st_phys_match, st_crc_err;
  logic        st_align_err, st_collision, st_other_err, host_valid;
  logic        host_ready, host_last, host_burst_end, rx_dma_active;
  logic        rx_accepted, received_error_flag, early_irq;
  logic [3:0]  reg_be;
  logic [7:0]  reg_addr, rx_data, host_data, last_data, burst_cnt, b0;
  logic [10:0] rx_fifo_bytes, rx_early_len, rx_frame_len, rx_burst_limit;
  logic [16:0] host_addr, ring_size, last_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv, fc;
  logic [19:0] ec;
  int          bad_count, n_tests, early_at, lim;
  logic [31:0] fcase [19];
  logic [19:0] ecase [4];
  localparam logic [7:0]  RA [4] = '{8'h44, 8'h5c, 8'h60, 8'h48};
  localparam logic [31:0] RB [4] = '{32'h0f03_ffbf, 32'hfff, 32'h0, 32'h0};

  rx_config_filter_dma i_rx_config_filter_dma (.clk, .rst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_be, .reg_wdata, .reg_rdata, .rx_valid,
    .rx_ready, .rx_data, .rx_last, .rx_fifo_bytes, .rx_fifo_pkt_complete,
    .rx_known_protocol, .rx_early_len, .st_broadcast, .st_multicast,
    .st_phys_match, .st_crc_err, .st_align_err, .st_collision, .st_other_err,
    .host_valid, .host_ready, .host_data, .host_addr, .host_last,
    .host_burst_end, .rx_dma_active, .rx_done, .rx_accepted,
    .received_error_flag, .rx_frame_len, .early_irq, .ring_size,
    .rx_burst_limit);
  host_mem_model i_host_mem_model (.clk, .rst_n, .host_valid, .host_ready,
    .host_data, .host_addr, .host_burst_end, .slow, .last_addr, .last_data,
    .burst_cnt);

  // 8 ns clock
  always #4 clk = ~clk;

  // ------------------
  // Access tasks
  // ------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clk);
    {reg_wr_en, reg_addr, reg_be, reg_wdata} = {1'b1, a, be, d};
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(negedge clk);
    reg_rd_en = 1'b0;
    rdv = reg_rdata;
  endtask
  // Byte n shown each low phase; counted if ready
  task automatic send(input logic [10:0] len, input logic [6:0] st);
    int i, k;
    i = 0;
    k = 0;
    early_at = 0;
    {st_broadcast, st_multicast, st_phys_match, st_crc_err, st_align_err,
     st_collision, st_other_err} = st;
    rx_fifo_pkt_complete = 1'b1;
    while (i < len && k < 20000) begin
      @(negedge clk);
      if (early_irq) early_at = i;
      {rx_valid, rx_data, rx_last} = {1'b1, i[7:0], i == len - 1};
      if (rx_ready) i++;
      k++;
    end
    @(negedge clk);
    {rx_valid, rx_last, rx_fifo_pkt_complete, rx_fifo_bytes} = '0;
    for (k = 0; k < 4 && rx_done !== 1'b1; k++) @(negedge clk);
    chk("verdict pulse", 32'h1, 32'(rx_done));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, well past the expected 40k cycles
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  // ------------------
  // Test sequence
  // ------------------
  initial begin
    {clk, rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_be, reg_wdata} = '0;
    {rx_valid, rx_data, rx_last, rx_fifo_bytes, rx_fifo_pkt_complete} = '0;
    {rx_known_protocol, rx_early_len, slow, bad_count, n_tests} = '0;
    {st_broadcast, st_multicast, st_phys_match, st_crc_err} = '0;
    {st_align_err, st_collision, st_other_err} = '0;
    fcase = '{32'h0840_0402, 32'h0440_0400, 32'h0420_0402, 32'h0210_0402,
              32'h0200_0400, 32'h0100_0402, 32'h0100_0280, 32'h1100_0282,
              32'h1100_0070, 32'h0108_0640, 32'h2108_0643, 32'h2108_0093,
              32'h2108_0080, 32'h0101_01e0, 32'h0101_0413, 32'h8101_0093,
              32'h8101_0080, 32'h2104_0643, 32'h0102_0640};
    ecase = '{20'h40128, 20'h40019, 20'h41119, 20'h00100};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int j = 0; j < 4; j++) begin
      rd(RA[j]);
      chk("reset value", 32'h0, rdv);
      wr(RA[j], 4'hf, 32'hffff_ffff);
      rd(RA[j]);
      chk("read back", RB[j], rdv);
    end
    wr(`RCFG_OFFSET, 4'h2, 32'h0);
    rd(`RCFG_OFFSET);
    chk("lane write", 32'h0f03_00bf, rdv);
    // Start level for every threshold code
    for (int c = 0; c < 8; c++) begin
      wr(`RCFG_OFFSET, 4'hf, {16'h0, c[2:0], 13'h0001});
      rx_fifo_bytes = (c == 7) ? 11'h7ff : (11'h010 << c) - 11'h001;
      repeat (4) @(negedge clk);
      chk("ready below level", 32'h0, 32'(rx_ready));
      rx_fifo_pkt_complete = (c == 7);
      rx_fifo_bytes = (c == 7) ? 11'h7ff : (11'h010 << c);
      repeat (2) @(negedge clk);
      chk("ready at level", 32'h1, 32'(rx_ready));
      send(11'd16, 7'h0);
    end
    // Address class and error policy table
    for (int j = 0; j < 19; j++) begin
      fc = fcase[j];
      wr(`RCFG_OFFSET, 4'hf, {15'h0, fc[31], 10'h0, fc[29:24]});
      send(fc[14:4], fc[22:16]);
      chk("acc", 32'(fc[1]), 32'(rx_accepted));
      chk("err", 32'(fc[0]), 32'(received_error_flag));
      chk("len", 32'(fc[14:4]), 32'(rx_frame_len));
    end
    // Early event point per protocol and select bit
    wr(`MULTI_IRQ_OFFSET, 4'h3, 32'h0000_0019);
    rx_early_len = 11'd160;
    for (int j = 0; j < 4; j++) begin
      ec = ecase[j];
      wr(`RCFG_OFFSET, 4'hf, {4'h0, ec[19:16], 6'h0, ec[12], 17'h00001});
      rx_known_protocol = ec[8];
      send(11'd100, 7'h0);
      chk("early point", 32'(ec[7:0]), 32'(early_at));
    end
    // Burst ends per burst code, 100-byte frames
    for (int c = 0; c < 8; c++) begin
      wr(`RCFG_OFFSET, 4'hf, {21'h0, c[2:0], 8'h01});
      b0 = burst_cnt;
      send(11'd100, 7'h0);
      repeat (4) @(negedge clk);
      lim = 16 << c;
      lim = (c == 7) ? 1 : (100 + lim - 1) / lim;
      chk("bursts", 32'(lim), 32'(burst_cnt - b0));
    end
    // Ring end crossing, wrap clear then set; slow host first
    for (int w = 0; w < 2; w++) begin
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      slow = (w == 0);
      wr(`RCFG_OFFSET, 4'hf, {24'h0, w[0], 7'h01});
      repeat (5) send(11'd1500, 7'h0);
      rd(`RING_PTR_OFFSET);
      chk("ring pointer", 32'd7500, rdv);
      send(11'd1500, 7'h0);
      repeat (8) @(negedge clk);
      chk("frame end", w ? 32'd8999 : 32'd807, 32'(last_addr));
      rd(`RING_PTR_OFFSET);
      chk("next start", 32'd808, rdv);
      send(11'd100, 7'h0);
      repeat (8) @(negedge clk);
      chk("after overflow", 32'd907, 32'(last_addr));
      chk("last byte", 32'h63, 32'(last_data));
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// file: rtl/host_buf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface host_buf_if;
  rx_cfg_pkg::host_word_t in_word;
  logic                   in_valid;
  logic                   in_ready;
  logic                   allow;
  rx_cfg_pkg::host_word_t out_word;
  logic                   out_valid;
  logic                   out_ready;

  modport owner (output in_word, in_valid, allow, out_ready,
                 input  in_ready, out_word, out_valid);
  modport store (input  in_word, in_valid, allow, out_ready,
                 output in_ready, out_word, out_valid);
endinterface
`default_nettype wire

// file: rtl/host_skid_buf.sv
`timescale 1ns/10ps
`default_nettype none
module host_skid_buf (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Both sides of the buffer
  host_buf_if.store  bi
);

  rx_cfg_pkg::buf_state_t s_reg;
  rx_cfg_pkg::buf_state_t s_next;
  logic                   take;
  logic                   pop;

  // Outputs come straight from the registered state
  assign bi.in_ready  = s_reg.in_ready;
  assign bi.out_word  = s_reg.out_word;
  assign bi.out_valid = s_reg.out_valid;
  assign take = bi.in_valid & s_reg.in_ready;
  assign pop  = s_reg.out_valid & bi.out_ready;

  // Skid slot catches the word taken while the drain stalls
  always_comb begin
    s_next = s_reg;
    if (pop || !s_reg.out_valid) begin
      if (s_reg.skid_valid) begin
        s_next.out_word   = s_reg.skid_word;
        s_next.out_valid  = 1'b1;
        s_next.skid_word  = bi.in_word;
        s_next.skid_valid = take;
      end else begin
        s_next.out_word   = bi.in_word;
        s_next.out_valid  = take;
      end
    end else if (take) begin
      s_next.skid_word  = bi.in_word;
      s_next.skid_valid = 1'b1;
    end
    // Ready only while the skid slot will be free: no word lost
    s_next.in_ready = !s_next.skid_valid && bi.allow;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// file: rtl/rx_cfg_defines.svh
`ifndef RX_CFG_DEFINES_SVH
`define RX_CFG_DEFINES_SVH
// Notes on behaviour
// R1: early threshold in sixteenths, zero disables
// R2: select set: every packet uses multi setting
// R3: select clear: known protocols use threshold
// R4: short error accept set: errors over 8
// R5: short error accept clear: errors over 64
// R6: error or runt accept: errors over 8
// R7: start transfer at threshold or whole packet
// R8: code 111 waits for the whole packet
// R9: ring length 8K to 64K plus 16
// R10: burst limit 16 to 1024, 111 unlimited
// R11: wrap clear: remainder goes to ring start
// R12: wrap set: remainder continues past ring end
// R13: host reserves 1.5K beyond ring end
// R14: next packet starts at overflow offset
// R15: wrap ignored with the 64K ring
// R16: error accept bit gates CRC/alignment/collision
// R17: runt accept takes 8 to 63 bytes
// R18: broadcast accept bit gates broadcasts
// R19: multicast accept bit gates multicasts
// R20: physical match bit gates own-address frames
// R21: accept-all bit takes any physical address
// R22: accept on address class and error policy
// R23: reserved bits read zero, writes ignored

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RCFG_OFFSET      8'h44
`define MULTI_IRQ_OFFSET 8'h5c
`define RING_PTR_OFFSET  8'h60

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define F_EARLY_THR   27:24
`define B_MULTI_SEL   17
`define B_SHORT_ERR   16
`define F_FIFO_THR    15:13
`define F_RING_LEN    12:11
`define F_BURST       10:8
`define B_WRAP        7
`define B_ACC_ERR     5
`define B_ACC_RUNT    4
`define B_ACC_BCAST   3
`define B_ACC_MCAST   2
`define B_ACC_PHYS    1
`define B_ACC_ALL     0
`define RCFG_WMASK    32'h0f03_ffbf
`define RCFG_RESET    32'h0000_0000
`define MULTI_RESET   12'h000

// ------------------------------------------------------------
// Sizes and limits
// ------------------------------------------------------------
`define RUNT_MIN_LEN  11'h008
`define FULL_MIN_LEN  11'h040
`define THR_BASE      11'h010
`define RING_BASE     17'h02000
`define WHOLE_PKT     3'h7
`define NO_LIMIT      3'h7
`define LARGEST_RING  2'h3
`endif

// file: rtl/rx_cfg_pkg.sv
package rx_cfg_pkg;

  // One word on its way to host memory
  typedef struct packed {
    logic [7:0]  data;
    logic [16:0] addr;
    logic        last;
    logic        burst_end;
  } host_word_t;

  // Two-entry buffer state
  typedef struct packed {
    host_word_t out_word;
    logic       out_valid;
    host_word_t skid_word;
    logic       skid_valid;
    logic       in_ready;
  } buf_state_t;

  // Receive configuration and transfer state
  typedef struct packed {
    logic [31:0] rcfg;
    logic [11:0] multi;
    logic [31:0] rd_data;
    logic        go;
    logic [10:0] pkt_cnt;
    logic [10:0] burst_cnt;
    logic [16:0] wr_ptr;
    logic [16:0] pkt_start;
    logic        done;
    logic        accepted;
    logic        err_flag;
    logic [10:0] frame_len;
    logic        early;
  } cfg_state_t;

endpackage

// file: rtl/rx_config_filter_dma.sv
`timescale 1ns/10ps
`default_nettype none
`include "rx_cfg_defines.svh"
module rx_config_filter_dma (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [3:0]  reg_be,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Byte stream from the receive FIFO
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic [10:0] rx_fifo_bytes,
  input  wire logic        rx_fifo_pkt_complete,
  // Frame attributes, valid with the first byte onward
  input  wire logic        rx_known_protocol,
  input  wire logic [10:0] rx_early_len,
  // Frame status, sampled with the last byte
  input  wire logic        st_broadcast,
  input  wire logic        st_multicast,
  input  wire logic        st_phys_match,
  input  wire logic        st_crc_err,
  input  wire logic        st_align_err,
  input  wire logic        st_collision,
  input  wire logic        st_other_err,
  // Writes toward host memory
  output logic             host_valid,
  input  wire logic        host_ready,
  output logic      [7:0]  host_data,
  output logic      [16:0] host_addr,
  output logic             host_last,
  output logic             host_burst_end,
  // Frame verdict and events
  output logic             rx_dma_active,
  output logic             rx_done,
  output logic             rx_accepted,
  output logic             received_error_flag,
  output logic      [10:0] rx_frame_len,
  output logic             early_irq,
  // Configuration for the bus-master engine
  output logic      [16:0] ring_size,
  output logic      [10:0] rx_burst_limit
);

  rx_cfg_pkg::cfg_state_t s_reg;
  rx_cfg_pkg::cfg_state_t s_next;
  host_buf_if             bi ();

  logic        take;
  logic [2:0]  thr_code;
  logic [10:0] thr_bytes;
  logic [16:0] ring_bytes;
  logic        wrap_at_end;
  logic [16:0] ptr_inc;
  logic [16:0] ptr_adv;
  logic [10:0] cnt_after;
  logic [10:0] burst_bytes;
  logic        burst_hit;
  logic [14:0] early_prod;
  logic [10:0] early_target;
  logic        addr_ok;
  logic        hard_err;
  logic        any_err;
  logic        err_ok;
  logic        len_ok;
  logic        frame_ok;
  logic [16:0] next_start;

  // ------------------------------------------------------------
  // Buffer toward host memory
  // ------------------------------------------------------------
  host_skid_buf u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .bi    (bi)
  );

  assign bi.in_valid          = rx_valid & s_reg.go;
  assign bi.in_word.data      = rx_data;
  assign bi.in_word.addr      = s_reg.wr_ptr;
  assign bi.in_word.last      = rx_last;
  assign bi.in_word.burst_end = rx_last | burst_hit;
  assign bi.allow             = s_next.go;
  assign bi.out_ready         = host_ready;

  // Outputs, each from a flop of the state or of the buffer
  assign rx_ready            = bi.in_ready;
  assign host_valid          = bi.out_valid;
  assign host_data           = bi.out_word.data;
  assign host_addr           = bi.out_word.addr;
  assign host_last           = bi.out_word.last;
  assign host_burst_end      = bi.out_word.burst_end;
  assign reg_rdata           = s_reg.rd_data;
  assign rx_dma_active       = s_reg.go;
  assign rx_done             = s_reg.done;
  assign rx_accepted         = s_reg.accepted;
  assign received_error_flag = s_reg.err_flag;
  assign rx_frame_len        = s_reg.frame_len;
  assign early_irq           = s_reg.early;

  // ------------------------------------------------------------
  // Decoded configuration
  // ------------------------------------------------------------
  assign take     = rx_valid & bi.in_ready;
  assign thr_code = s_reg.rcfg[`F_FIFO_THR];
  // Start level as a power of two from 16 bytes
  assign thr_bytes = `THR_BASE << thr_code; // R7
  // Ring span from 8K; the extra 16 bytes are host slack only
  assign ring_bytes = `RING_BASE << s_reg.rcfg[`F_RING_LEN]; // R9
  // Largest ring always wraps, whatever the wrap bit says
  assign wrap_at_end = !s_reg.rcfg[`B_WRAP] ||
                       (s_reg.rcfg[`F_RING_LEN] == `LARGEST_RING); // R15
  assign ptr_inc = s_reg.wr_ptr + 17'h00001;
  // Wrap to the ring start or run on past its end
  assign ptr_adv = (ptr_inc == ring_bytes && wrap_at_end) ?
                   17'h00000 : ptr_inc; // R11 R12
  assign cnt_after = s_reg.pkt_cnt + 11'h001;

  // Burst cap; unlimited bursts end only with the packet
  assign burst_bytes = `THR_BASE << s_reg.rcfg[`F_BURST]; // R10
  assign burst_hit   = (s_reg.rcfg[`F_BURST] != `NO_LIMIT) &&
                       (s_reg.burst_cnt + 11'h001 == burst_bytes); // R10

  // ------------------------------------------------------------
  // Early receive target
  // ------------------------------------------------------------
  assign early_prod = rx_early_len * s_reg.rcfg[`F_EARLY_THR]; // R1
  always_comb begin
    if (s_reg.rcfg[`B_MULTI_SEL] || !rx_known_protocol) begin
      early_target = s_reg.multi[10:0]; // R2 R3
      if (s_reg.multi[11]) begin
        early_target = 11'h7ff;
      end
    end else begin
      early_target = early_prod[14:4]; // R1 R3
    end
  end

  // ------------------------------------------------------------
  // Frame acceptance
  // ------------------------------------------------------------
  // Physical address means neither broadcast nor multicast
  assign addr_ok = (st_broadcast  & s_reg.rcfg[`B_ACC_BCAST]) | // R18
                   (st_multicast  & s_reg.rcfg[`B_ACC_MCAST]) | // R19
                   (st_phys_match & s_reg.rcfg[`B_ACC_PHYS])  | // R20
                   (!st_broadcast & !st_multicast &
                    s_reg.rcfg[`B_ACC_ALL]); // R21
  assign hard_err = st_crc_err | st_align_err | st_collision;
  assign any_err  = hard_err | st_other_err;

  always_comb begin
    err_ok = 1'b1;
    if (s_reg.rcfg[`B_ACC_ERR] || s_reg.rcfg[`B_ACC_RUNT]) begin
      // Short error accept is a don't-care here
      err_ok = cnt_after > `RUNT_MIN_LEN; // R6
    end else if (s_reg.rcfg[`B_SHORT_ERR]) begin
      err_ok = cnt_after > `RUNT_MIN_LEN; // R4
    end else begin
      err_ok = cnt_after > `FULL_MIN_LEN; // R5
    end
    // CRC, alignment and collision damage need the error bit
    if (hard_err && !s_reg.rcfg[`B_ACC_ERR]) begin
      err_ok = 1'b0; // R16
    end
    if (!any_err) begin
      err_ok = 1'b1;
    end
  end

  // Error-free runts of 8 to 63 bytes only with the runt bit
  assign len_ok = (cnt_after >= `FULL_MIN_LEN) ||
                  (s_reg.rcfg[`B_ACC_RUNT] &&
                   cnt_after >= `RUNT_MIN_LEN) ||
                  (any_err && err_ok); // R17
  assign frame_ok = addr_ok && err_ok && len_ok; // R22

  // Overflow of X bytes past the end starts the next packet at X
  assign next_start = (ptr_adv >= ring_bytes) ?
                      ptr_adv - ring_bytes : ptr_adv; // R14

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.early = 1'b0;

    // Register writes by byte lane; reserved bits stay zero
    if (reg_wr_en && reg_addr == `RCFG_OFFSET) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_be[i]) begin
          s_next.rcfg[8*i +: 8] = reg_wdata[8*i +: 8];
        end
      end
      s_next.rcfg = s_next.rcfg & `RCFG_WMASK; // R23
    end
    if (reg_wr_en && reg_addr == `MULTI_IRQ_OFFSET) begin
      if (reg_be[0]) begin
        s_next.multi[7:0] = reg_wdata[7:0];
      end
      if (reg_be[1]) begin
        s_next.multi[11:8] = reg_wdata[11:8];
      end
    end

    // Read data, unmapped offsets read zero
    if (reg_rd_en) begin
      case (reg_addr)
        `RCFG_OFFSET:      s_next.rd_data = s_reg.rcfg; // R23
        `MULTI_IRQ_OFFSET: s_next.rd_data = {20'h00000, s_reg.multi};
        `RING_PTR_OFFSET:  s_next.rd_data = {15'h0000, s_reg.wr_ptr};
        default:           s_next.rd_data = 32'h0000_0000;
      endcase
    end

    // Start the transfer at the level or with a whole packet
    if (!s_reg.go) begin
      if (rx_fifo_pkt_complete) begin
        s_next.go = 1'b1; // R7 R8
      end else if (thr_code != `WHOLE_PKT &&
                   rx_fifo_bytes >= thr_bytes) begin
        s_next.go = 1'b1; // R7
      end
    end

    if (take) begin
      s_next.wr_ptr    = ptr_adv;
      s_next.pkt_cnt   = cnt_after;
      s_next.burst_cnt = burst_hit ? 11'h000 : s_reg.burst_cnt + 11'h001;
      // Early event fires once as the count passes its target
      if (early_target != 11'h000 && cnt_after == early_target) begin
        s_next.early = 1'b1; // R1 R2 R3
      end
      if (rx_last) begin
        s_next.go        = 1'b0;
        s_next.pkt_cnt   = 11'h000;
        s_next.burst_cnt = 11'h000;
        s_next.done      = 1'b1;
        s_next.accepted  = frame_ok; // R22
        s_next.err_flag  = frame_ok && any_err; // R6
        s_next.frame_len = cnt_after;
        // Rejected frames give their ring space back
        if (frame_ok) begin
          s_next.wr_ptr    = next_start; // R14
          s_next.pkt_start = next_start;
        end else begin
          s_next.wr_ptr    = s_reg.pkt_start; // R22
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg       <= '0;
      s_reg.rcfg  <= `RCFG_RESET; // R5
      s_reg.multi <= `MULTI_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Engine configuration, registered for a clean fan-out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_size      <= `RING_BASE;
      rx_burst_limit <= `THR_BASE;
    end else begin
      ring_size      <= ring_bytes; // R9
      // Zero stands for no limit
      rx_burst_limit <= (s_reg.rcfg[`F_BURST] == `NO_LIMIT) ?
                        11'h000 : burst_bytes; // R10
    end
  end

endmodule
`default_nettype wire
